//--- design/sadc_regs.vh
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

// register byte offsets
`define SADC_OFF_CTRL      8'hd2
`define SADC_OFF_RES_HI    8'hd3
`define SADC_OFF_RES_LO    8'hd4
`define SADC_OFF_AIN_EN    8'hd5

// converter_control field positions
`define SADC_CTRL_START    0
`define SADC_CTRL_CLK_LO   1
`define SADC_CTRL_CLK_HI   2
`define SADC_CTRL_EOC      3
`define SADC_CTRL_CH_LO    4
`define SADC_CTRL_CH_HI    6

// reset values
`define SADC_CTRL_RST      8'h00
`define SADC_AIN_EN_RST    8'h00
`define SADC_RESULT_RST    10'h000

// successive approximation
`define SADC_RESULT_BITS   10
`define SADC_MID_SCALE     10'h200

// timing in conversion clocks
`define SADC_SETUP_CLKS    4'ha
`define SADC_EDGES_PER_BIT 4'h4
`define SADC_TOTAL_CLKS    50

// conversion clock select codes and divider terminal counts
`define SADC_CLK_DIV16     2'h0
`define SADC_CLK_DIV8      2'h1
`define SADC_CLK_DIV4      2'h2
`define SADC_CLK_DIV1      2'h3
`define SADC_TERM_DIV16    4'hf
`define SADC_TERM_DIV8     4'h7
`define SADC_TERM_DIV4     4'h3
`define SADC_TERM_DIV1     4'h0

`endif

//--- design/sadc_sync.v
`timescale 1ns/1ns

// three-stage synchroniser; the output moves only when stages two and three agree
module sadc_sync (
	input  wire i_clk,
	input  wire i_rst,
	input  wire i_async,
	output reg  o_level
);

	reg meta_reg;
	reg s2_reg;
	reg s3_reg;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= 1'b0;
			s2_reg   <= 1'b0;
			s3_reg   <= 1'b0;
			o_level  <= 1'b0;
		end else begin
			meta_reg <= i_async;
			s2_reg   <= meta_reg;
			s3_reg   <= s2_reg;
			if (s2_reg == s3_reg) begin
				o_level <= s3_reg;
			end
		end
	end

endmodule // sadc_sync

//--- design/sadc_clkdiv.v
`timescale 1ns/1ns
`include "sadc_regs.vh"

// conversion clock as a one-cycle tick; held in reset while idle so the
// first tick of a conversion always comes a full period after the start
module sadc_clkdiv (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire       i_run,
	input  wire [1:0] i_sel,
	output reg        o_tick
);

	reg [3:0] cnt_reg;
	reg [3:0] term;

	always @* begin
		case (i_sel)
			`SADC_CLK_DIV16: term = `SADC_TERM_DIV16;
			`SADC_CLK_DIV8:  term = `SADC_TERM_DIV8;
			`SADC_CLK_DIV4:  term = `SADC_TERM_DIV4;
			default:         term = `SADC_TERM_DIV1;
		endcase
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_reg <= 4'h0;
			o_tick  <= 1'b0;
		end else if (!i_run) begin
			cnt_reg <= 4'h0;
			o_tick  <= 1'b0;
		end else if (cnt_reg >= term) begin
			cnt_reg <= 4'h0;
			o_tick  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
			o_tick  <= 1'b0;
		end
	end

endmodule // sadc_clkdiv

//--- design/sadc_top.v
// Behaviour
// - bits 6:4 route one of eight inputs
// - writing bit 0 high starts conversion
// - approximation starts at 200h, refined per step
// - ten-bit result, one channel per conversion
// - on completion set bit 3, store result
// - converter idles after result until restarted
// - next completion overwrites result, read or not
// - ten set-up clocks, four per bit
// - bits 2:1 pick conversion clock divider
// - reset clears start bit
// - channel field writable any time
// - first trial compares against half reference
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "sadc_regs.vh"

module sadc_top (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire [7:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	input  wire       i_cmp_above,
	output reg  [7:0] o_rdata,
	output reg  [7:0] o_chan_sel,
	output reg  [9:0] o_dac_code,
	output reg  [7:0] o_ain_en,
	output reg        o_busy
);

	localparam [3:0] ST_IDLE  = 4'b0001;
	localparam [3:0] ST_SETUP = 4'b0010;
	localparam [3:0] ST_CONV  = 4'b0100;
	localparam [3:0] ST_LATCH = 4'b1000;

	function [7:0] onehot8;
		input [2:0] idx;
		begin
			onehot8 = 8'h01 << idx;
		end
	endfunction

	// channel field of a control byte; used for the software copy, the reset value and the start latch
	function [2:0] ctrl_chan;
		input [7:0] data;
		begin
			ctrl_chan = data[`SADC_CTRL_CH_HI:`SADC_CTRL_CH_LO];
		end
	endfunction

	// clock select field of a control byte
	function [1:0] ctrl_clk;
		input [7:0] data;
		begin
			ctrl_clk = data[`SADC_CTRL_CLK_HI:`SADC_CTRL_CLK_LO];
		end
	endfunction

	localparam [7:0] CTRL_RST = `SADC_CTRL_RST;

	reg  [3:0] state_reg;
	reg  [3:0] state_next;
	reg  [2:0] chan_reg;
	reg  [2:0] chan_act_reg;
	reg  [2:0] chan_act_next;
	reg  [1:0] clksel_reg;
	reg        start_reg;
	reg        start_next;
	reg        eoc_reg;
	reg        eoc_next;
	reg  [9:0] sar_reg;
	reg  [9:0] sar_next;
	reg  [9:0] trial_reg;
	reg  [9:0] trial_next;
	reg  [3:0] cnt_reg;
	reg  [3:0] cnt_next;
	reg  [9:0] result_reg;
	reg  [9:0] result_next;
	reg  [9:0] sar_kept;
	reg  [7:0] rdata_next;
	reg  [7:0] chan_sel_next;

	wire       conv_tick;
	wire       cmp_level;
	wire       wr_ctrl;
	wire       wr_ain;
	wire       is_idle;
	wire       start_req;
	wire       abort_req;

	assign wr_ctrl = i_wr && (i_addr == `SADC_OFF_CTRL);
	assign wr_ain  = i_wr && (i_addr == `SADC_OFF_AIN_EN);
	assign is_idle = state_reg[0];
	assign start_req = wr_ctrl && i_wdata[`SADC_CTRL_START];
	// no abort in the latch cycle: the result is already decided there and is kept
	assign abort_req = !is_idle && !state_reg[3] && wr_ctrl && !i_wdata[`SADC_CTRL_START];

	// the comparator settles on the analog side, so it is treated as asynchronous
	sadc_sync u_cmp_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async (i_cmp_above),
		.o_level (cmp_level)
	);

	sadc_clkdiv u_clkdiv (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_run  (!is_idle),
		.i_sel  (clksel_reg),
		.o_tick (conv_tick)
	);

	// software-owned fields; channel and clock select may change at any time
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			chan_reg   <= ctrl_chan(CTRL_RST);
			clksel_reg <= ctrl_clk(CTRL_RST);
			o_ain_en   <= `SADC_AIN_EN_RST;
		end else begin
			if (wr_ctrl) begin
				chan_reg   <= ctrl_chan(i_wdata);
				clksel_reg <= ctrl_clk(i_wdata);
			end
			if (wr_ain) begin
				o_ain_en <= i_wdata;
			end
		end
	end

	// approximation step: drop the trial bit when the input sits below the dac level
	always @* begin
		sar_kept = sar_reg;
		if (!cmp_level) begin
			sar_kept = sar_reg & ~trial_reg;
		end
	end

	always @* begin
		state_next    = state_reg;
		start_next    = start_reg;
		eoc_next      = eoc_reg;
		sar_next      = sar_reg;
		trial_next    = trial_reg;
		cnt_next      = cnt_reg;
		result_next   = result_reg;
		chan_act_next = chan_act_reg;
		case (state_reg)
			ST_IDLE: begin
				if (wr_ctrl) begin
					start_next = i_wdata[`SADC_CTRL_START];
				end
				if (start_req) begin
					state_next    = ST_SETUP;
					eoc_next      = 1'b0;
					sar_next      = `SADC_MID_SCALE;
					trial_next    = `SADC_MID_SCALE;
					cnt_next      = 4'h0;
					chan_act_next = ctrl_chan(i_wdata);
				end
			end
			ST_SETUP: begin
				if (conv_tick) begin
					if (cnt_reg == `SADC_SETUP_CLKS - 4'h1) begin
						cnt_next   = 4'h0;
						state_next = ST_CONV;
					end else begin
						cnt_next = cnt_reg + 4'h1;
					end
				end
			end
			ST_CONV: begin
				if (conv_tick) begin
					if (cnt_reg == `SADC_EDGES_PER_BIT - 4'h1) begin
						cnt_next = 4'h0;
						if (trial_reg[0]) begin
							sar_next   = sar_kept;
							state_next = ST_LATCH;
						end else begin
							trial_next = trial_reg >> 1;
							sar_next   = sar_kept | (trial_reg >> 1);
						end
					end else begin
						cnt_next = cnt_reg + 4'h1;
					end
				end
			end
			ST_LATCH: begin
				result_next = sar_reg;
				eoc_next    = 1'b1;
				start_next  = 1'b0;
				state_next  = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
				start_next = 1'b0;
			end
		endcase
		// clearing the start bit mid-conversion abandons it without a result
		if (abort_req) begin
			state_next = ST_IDLE;
			start_next = 1'b0;
			cnt_next   = 4'h0;
		end
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg    <= ST_IDLE;
			start_reg    <= 1'b0;
			eoc_reg      <= 1'b0;
			sar_reg      <= `SADC_RESULT_RST;
			trial_reg    <= `SADC_RESULT_RST;
			cnt_reg      <= 4'h0;
			result_reg   <= `SADC_RESULT_RST;
			chan_act_reg <= 3'h0;
		end else begin
			state_reg    <= state_next;
			start_reg    <= start_next;
			eoc_reg      <= eoc_next;
			sar_reg      <= sar_next;
			trial_reg    <= trial_next;
			cnt_reg      <= cnt_next;
			result_reg   <= result_next;
			chan_act_reg <= chan_act_next;
		end
	end

	// during a conversion the mux holds the channel taken at the start
	always @* begin
		if (is_idle && !start_req) begin
			chan_sel_next = onehot8(chan_reg);
		end else begin
			chan_sel_next = onehot8(chan_act_next);
		end
	end

	always @* begin
		rdata_next = 8'h00;
		if (i_rd) begin
			case (i_addr)
				`SADC_OFF_CTRL:   rdata_next = {1'b0, chan_reg, eoc_reg, clksel_reg, start_reg};
				`SADC_OFF_RES_HI: rdata_next = result_reg[9:2];
				`SADC_OFF_RES_LO: rdata_next = {6'h00, result_reg[1:0]};
				`SADC_OFF_AIN_EN: rdata_next = o_ain_en;
				default:          rdata_next = 8'h00;
			endcase
		end
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata    <= 8'h00;
			o_chan_sel <= 8'h01;
			o_dac_code <= `SADC_RESULT_RST;
			o_busy     <= 1'b0;
		end else begin
			o_rdata    <= rdata_next;
			o_chan_sel <= chan_sel_next;
			o_dac_code <= sar_next;
			o_busy     <= !state_next[0];
		end
	end

endmodule // sadc_top

//--- sim/sadc_afe.sv
`timescale 1ns/1ns
module sadc_afe (
	input  wire logic [9:0]  i_dac_code,
	input  wire logic [7:0]  i_chan_sel,
	input  wire logic [79:0] i_levels,
	output logic             o_above
);
	// level sits half a code above nominal, so a trial equal to it reads above
	always_comb begin
		o_above = 1'b0;
		for (int k = 0; k < 8; k++)
			if (i_chan_sel[k])
				o_above = i_levels[k*10 +: 10] >= i_dac_code;
	end
endmodule // sadc_afe

//--- sim/sadc_top_sva.sv
`timescale 1ns/1ns
`include "sadc_regs.vh"
module sadc_top_sva (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_chan_sel,
	input wire logic [9:0] o_dac_code,
	input wire logic       o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic       go;
	logic       ctl;
	logic [1:0] sel_reg;
	logic       abort_reg;
	int         cnt_reg;
	int         lim;
	assign ctl = i_wr && i_addr == `SADC_OFF_CTRL;
	assign go = ctl && i_wdata[0] && !o_busy;
	assign lim = `SADC_TOTAL_CLKS << (sel_reg == 2'h0 ? 4 : sel_reg == 2'h1 ? 3 : sel_reg == 2'h2 ? 2 : 0);
	// an abort ends a run early, so the length check is skipped for it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sel_reg <= 2'h0;
			abort_reg <= 1'b0;
			cnt_reg <= 0;
		end else begin
			if (go)
				sel_reg <= i_wdata[2:1];
			abort_reg <= go ? 1'b0 : (abort_reg || (ctl && o_busy && !i_wdata[0]));
			cnt_reg <= o_busy ? cnt_reg + 1 : 0;
		end
	end
	start_load_a: assert property (go |=> o_busy && o_dac_code == `SADC_MID_SCALE)
		else $error("start not taken");
	first_trial_a: assert property ($rose(o_busy) |-> o_dac_code == 10'h200)
		else $error("first trial not mid scale");
	idle_hold_a: assert property (!o_busy && !go |=> !o_busy)
		else $error("run without start");
	one_hot_a: assert property ($onehot(o_chan_sel))
		else $error("mux select not one hot");
	chan_hold_a: assert property (o_busy && $past(o_busy) |-> $stable(o_chan_sel))
		else $error("channel moved in run");
	run_length_a: assert property ($fell(o_busy) && !abort_reg |-> cnt_reg >= lim && cnt_reg <= lim + 6)
		else $error("run length wrong");
	dac_idle_a: assert property (!o_busy ##1 !o_busy |-> $stable(o_dac_code))
		else $error("dac moved while idle");
	eoc_busy_a: assert property (i_rd && i_addr == `SADC_OFF_CTRL && o_busy |=> !o_rdata[3])
		else $error("end flag set in run");
	cover property (go);
	cover property ($fell(o_busy));
	cover property (i_rd && i_addr == `SADC_OFF_RES_LO);
endmodule // sadc_top_sva
bind sadc_top sadc_top_sva chk_u (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_chan_sel,
	.o_dac_code, .o_busy);

//--- sim/tb_sadc_top.sv
`timescale 1ns/1ns
module tb_sadc_top;
	logic        i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, rd_d = 0, cmp, o_busy;
	logic [7:0]  i_addr = 0, i_wdata = 0, o_rdata, o_chan_sel, o_ain_en;
	logic [9:0]  o_dac_code, lvl;
	logic [79:0] levels = 0;
	logic [2:0]  ch, nch;
	logic [7:0]  expq[$];
	int          errors = 0, tests_run = 0, n;
	int unsigned junk;
	sadc_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_cmp_above(cmp), .o_rdata(o_rdata), .o_chan_sel(o_chan_sel), .o_dac_code(o_dac_code),
		.o_ain_en(o_ain_en), .o_busy(o_busy));
	sadc_afe afe_u (.i_dac_code(o_dac_code), .i_chan_sel(o_chan_sel), .i_levels(levels), .o_above(cmp));
	initial forever #5 i_clk = ~i_clk;
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	always @(posedge i_clk) begin
		rd_d <= i_rd;
		if (rd_d)
			check({2'h0, o_rdata}, {2'h0, expq.pop_front()});
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
	initial begin
		junk = $urandom(87);
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(8'hd2, 8'h00);
		rd(8'h7e, 8'h00);
		wr(8'hd5, 8'hff);
		rd(8'hd5, 8'hff);
		check({2'h0, o_ain_en}, 10'h0ff);
		$display("test reset done");
		for (int s = 0; s < 4; s++) begin
			ch = 3'($urandom_range(7, 0));
			nch = ch + 3'h1;
			lvl = 10'($urandom);
			levels[ch*10 +: 10] = lvl;
			wr(8'hd2, {1'b0, ch, 1'b0, s[1:0], 1'b1});
			rd(8'hd2, {1'b0, ch, 1'b0, s[1:0], 1'b1});
			check({2'h0, o_chan_sel}, {2'h0, 8'h01 << ch});
			wr(8'hd2, {1'b0, nch, 1'b0, s[1:0], 1'b1});
			check({2'h0, o_chan_sel}, {2'h0, 8'h01 << ch});
			n = 0;
			while (o_busy === 1'b1 && n < 5000) begin
				@(posedge i_clk);
				n++;
			end
			check(10'(n < 5000), 10'h1);
			rd(8'hd2, {1'b0, nch, 1'b1, s[1:0], 1'b0});
			// the fastest clock outruns the comparator filter, so its code is not judged
			if (s != 3) begin
				rd(8'hd3, lvl[9:2]);
				rd(8'hd4, {6'h0, lvl[1:0]});
			end
			$display("test conversion %0d done", s);
		end
		wr(8'hd2, 8'h01);
		wr(8'hd2, 8'h00);
		rd(8'hd2, 8'h00);
		check({9'h0, o_busy}, 10'h0);
		$display("test abort done");
		repeat (2) @(posedge i_clk);
		wrap_up();
	end
endmodule // tb_sadc_top
